// ### hdl/lcc_ctrl.sv
// LCD control, segment gating and contrast mode selection, Avalon-MM slave.
// Assumes synchronous inputs, one system clock, battery comparator is async.
`timescale 1ns/1ps

// Function
// - Control bit 7 reads zero, written zero
// - Clock divide code gives 1, 2, 4
// - Blank bit turns every segment off
// - Size bit selects 16 or 32 pins
// - Mux field selects static to four-mux
// - Bias bit third or half, ignored static
// - Contrast setpoint steps sixty millivolts upward
// - Mode decoded from four scattered bits
// - Mode 1 bypasses rail to battery
// - Mode 2 bypass, pump when battery low
// - Mode 3 regulates, pump when battery low
// - Mode 4 regulates, bypass when battery low
// - Mode 4 never enables the charge pump
// - Each nibble bit drives one backplane segment
// - Unused nibble bits per mux mode ignored
module lcc_ctrl
    import lcc_pkg::*;
(
    // Clock and reset
    input  wire logic           CLK_SYS_I,
    input  wire logic           SYS_RST_I,
    // Avalon-MM slave
    input  wire logic [9:0]     AVS_ADDRESS_I,
    input  wire logic           AVS_READ_I,
    input  wire logic           AVS_WRITE_I,
    input  wire logic [3:0]     AVS_BYTEENABLE_I,
    input  wire logic [31:0]    AVS_WRITEDATA_I,
    output logic      [31:0]    AVS_READDATA_O,
    output wire logic           AVS_WAITREQUEST_O,
    // Oscillator and battery comparator
    input  wire logic           LFO_CLK_I,
    input  wire logic           VBAT_LOW_I,
    // Segment and backplane setup
    output logic      [127:0]   SEG_STATE_O,
    output logic      [31:0]    SEG_PIN_EN_O,
    output logic      [1:0]     MUX_MODE_O,
    output logic                BIAS_HALF_O,
    output wire logic           LCD_TICK_O,
    // Display supply rail control
    output logic      [4:0]     CONTRAST_SET_O,
    output logic                RAIL_BYPASS_O,
    output logic                RAIL_REGULATE_O,
    output logic                PUMP_EN_O
);
    // ------------------------------------------------------------------
    // Registers and bus decode
    // ------------------------------------------------------------------
    logic [6:0]  control_q;
    logic [4:0]  contrast_q;
    logic [6:0]  master_q;
    logic [7:0]  mcfg_q;
    logic [7:0]  power_q;
    logic [7:0]  batmon_q;
    logic [1:0]  rd_cnt_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [7:0]  word_idx;
    logic        aligned;
    logic        wr_fire;
    logic        wr_lane0;
    logic [7:0]  wbyte;
    logic [SEG_BYTES-1:0] data_hit_vec;
    logic        data_hit;
    logic [3:0]  data_slot;
    logic        hit_control;
    logic        hit_contrast;
    logic        hit_master;
    logic        hit_mcfg;
    logic        hit_power;
    logic        hit_batmon;
    logic        hit_status;

    lcc_mem_if mem_bus ();

    assign word_idx     = AVS_ADDRESS_I[9:2];
    assign aligned      = AVS_ADDRESS_I[1:0] == 2'h0;
    assign hit_control  = aligned && word_idx == IDX_CONTROL;
    assign hit_contrast = aligned && word_idx == IDX_CONTRAST;
    assign hit_master   = aligned && word_idx == IDX_MASTER;
    assign hit_mcfg     = aligned && word_idx == IDX_MCFG;
    assign hit_power    = aligned && word_idx == IDX_POWER;
    assign hit_batmon   = aligned && word_idx == IDX_BATMON;
    assign hit_status   = aligned && word_idx == IDX_STATUS;

    genvar g;
    generate
        for (g = 0; g < SEG_BYTES; g++) begin : g_data_hit
            assign data_hit_vec[g] = aligned && word_idx == DATA_IDX[g];
        end
    endgenerate

    function automatic logic [3:0] slot_of(input logic [SEG_BYTES-1:0] v);
        logic [3:0] s;
        s = 4'h0;
        for (int k = 0; k < SEG_BYTES; k++) begin
            if (v[k]) begin
                s = 4'(k);
            end
        end
        return s;
    endfunction

    assign data_hit  = |data_hit_vec;
    assign data_slot = slot_of(data_hit_vec);

    // Writes never wait; reads wait two cycles for registered data
    assign AVS_WAITREQUEST_O = AVS_READ_I && rd_cnt_q != RD_LAST;
    assign wr_fire  = AVS_WRITE_I && !AVS_READ_I;
    assign wr_lane0 = wr_fire && AVS_BYTEENABLE_I[0];
    assign wbyte    = AVS_WRITEDATA_I[7:0];

    assign mem_bus.we    = wr_lane0 && data_hit;
    assign mem_bus.waddr = data_slot;
    assign mem_bus.wdata = wbyte;
    assign mem_bus.raddr = data_slot;

    lcc_seg_mem u_seg_mem (
        .CLK_SYS_I (CLK_SYS_I),
        .SYS_RST_I (SYS_RST_I),
        .mem       (mem_bus)
    );

    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            control_q  <= RST_CONTROL[6:0];
            contrast_q <= RST_CONTRAST[CNT_WIDTH-1:0];
            master_q   <= RST_MASTER[6:0];
            mcfg_q     <= RST_MCFG;
            power_q    <= RST_POWER;
            batmon_q   <= RST_BATMON;
        end else if (wr_lane0) begin
            if (hit_control)  control_q  <= wbyte[6:0];
            if (hit_contrast) contrast_q <= wbyte[CNT_WIDTH-1:0];
            if (hit_master)   master_q   <= wbyte[6:0];
            if (hit_mcfg)     mcfg_q     <= wbyte;
            if (hit_power)    power_q    <= wbyte;
            if (hit_batmon)   batmon_q   <= wbyte;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    logic      battery_low_q;
    lcc_mode_t mode_q;

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit_control)  rdata_d = {25'h0, control_q};
        if (hit_contrast) rdata_d = {27'h0, contrast_q};
        if (hit_master)   rdata_d = {25'h0, master_q};
        if (hit_mcfg)     rdata_d = {24'h0, mcfg_q};
        if (hit_power)    rdata_d = {24'h0, power_q};
        if (hit_batmon)   rdata_d = {24'h0, batmon_q};
        if (hit_status) begin
            rdata_d = {23'h0, battery_low_q, PUMP_EN_O, RAIL_REGULATE_O,
                       RAIL_BYPASS_O, mode_q};
        end
        if (data_hit)     rdata_d = {24'h0, mem_bus.rdata};
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            rd_cnt_q <= 2'h0;
            rdata_q  <= 32'h0000_0000;
        end else begin
            if (AVS_READ_I && AVS_WAITREQUEST_O) begin
                rd_cnt_q <= 2'(rd_cnt_q + 2'h1);
            end else begin
                rd_cnt_q <= 2'h0;
            end
            if (rd_cnt_q == 2'h1) begin
                rdata_q <= rdata_d;
            end
        end
    end
    assign AVS_READDATA_O = rdata_q;

    // ------------------------------------------------------------------
    // LCD tick and battery comparator
    // ------------------------------------------------------------------
    logic lcd_tick;
    logic vbat_meta_q;
    logic vbat_sync_q;

    lcc_tick_div u_tick_div (
        .CLK_SYS_I (CLK_SYS_I),
        .SYS_RST_I (SYS_RST_I),
        .osc_i     (LFO_CLK_I),
        .div_i     (control_q[CTL_DIV_LO+1:CTL_DIV_LO]),
        .tick_o    (lcd_tick)
    );
    assign LCD_TICK_O = lcd_tick;

    // two stages, then taken on tick
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            vbat_meta_q   <= 1'b0;
            vbat_sync_q   <= 1'b0;
            battery_low_q <= 1'b0;
        end else begin
            vbat_meta_q <= VBAT_LOW_I;
            vbat_sync_q <= vbat_meta_q;
            if (lcd_tick) battery_low_q <= vbat_sync_q;
        end
    end

    // ------------------------------------------------------------------
    // Contrast mode selection
    // ------------------------------------------------------------------
    logic      msc_lowdrv;
    logic      cfg_bypass;
    logic      pwr_pump;
    logic      bmon_en;
    lcc_mode_t dec_mode;
    logic      bypass_d;
    logic      regulate_d;
    logic      pump_d;

    assign msc_lowdrv = master_q[MST_LOWDRV];
    assign cfg_bypass = mcfg_q[MCFG_BYPASS];
    assign pwr_pump   = power_q[PWR_PUMP];
    assign bmon_en    = batmon_q[BMON_ENABLE];

    // low-drive bit free in modes 3, 4
    assign dec_mode =
        (!msc_lowdrv && cfg_bypass && !pwr_pump && !bmon_en) ? MODE_BYPASS :
        (!msc_lowdrv && cfg_bypass &&  pwr_pump &&  bmon_en) ? MODE_MIN    :
        (!cfg_bypass &&  pwr_pump && bmon_en)                ? MODE_CONST  :
        (!cfg_bypass && !pwr_pump && bmon_en)                ? MODE_AUTO   :
                                                               MODE_OFF;

    always_comb begin
        bypass_d   = 1'b0;
        regulate_d = 1'b0;
        pump_d     = 1'b0;
        case (dec_mode)
            MODE_BYPASS: bypass_d = 1'b1;
            MODE_MIN: begin
                bypass_d = !vbat_sync_q;
                pump_d   = vbat_sync_q;
            end
            MODE_CONST: begin
                regulate_d = !vbat_sync_q;
                pump_d     = vbat_sync_q;
            end
            MODE_AUTO: begin
                regulate_d = !vbat_sync_q;
                bypass_d   = vbat_sync_q;
            end
            default: bypass_d = 1'b0;
        endcase
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            mode_q          <= MODE_OFF;
            RAIL_BYPASS_O   <= 1'b0;
            RAIL_REGULATE_O <= 1'b0;
            PUMP_EN_O       <= 1'b0;
        end else if (lcd_tick) begin
            mode_q          <= dec_mode;
            RAIL_BYPASS_O   <= bypass_d;
            RAIL_REGULATE_O <= regulate_d;
            PUMP_EN_O       <= pump_d;
        end
    end

    // ------------------------------------------------------------------
    // Segment gating
    // ------------------------------------------------------------------
    logic [1:0]   mux_sel;
    logic [3:0]   use_mask;
    logic         blank;
    logic         size32;
    logic         disp_on;
    logic [127:0] seg_d;
    logic [31:0]  pin_en_d;

    assign mux_sel  = control_q[CTL_MUX_LO+1:CTL_MUX_LO];
    assign blank    = control_q[CTL_BLANK];
    assign size32   = control_q[CTL_SIZE];
    assign disp_on  = master_q[MST_ENABLE];
    // only the low bits the mux needs
    assign use_mask = 4'(4'hF >> (MUX_FOUR - mux_sel));

    generate
        for (g = 0; g < 32; g++) begin : g_pin
            // upper pins only in 32 pin size
            assign pin_en_d[g] = (g < 16) || size32;
            assign seg_d[4*g+3:4*g] = mem_bus.image[4*g+3:4*g] & use_mask
                                    & {4{disp_on && !blank && pin_en_d[g]}};
        end
    endgenerate

    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            SEG_STATE_O    <= 128'h0;
            SEG_PIN_EN_O   <= 32'h0000_0000;
            MUX_MODE_O     <= MUX_STATIC;
            BIAS_HALF_O    <= 1'b0;
            CONTRAST_SET_O <= RST_CONTRAST[CNT_WIDTH-1:0];
        end else if (lcd_tick) begin
            SEG_STATE_O    <= seg_d;
            SEG_PIN_EN_O   <= pin_en_d;
            MUX_MODE_O     <= mux_sel;
            BIAS_HALF_O    <= control_q[CTL_BIAS] && mux_sel != MUX_STATIC;
            CONTRAST_SET_O <= contrast_q;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_tick_mode(lcc_mode_t m);
        lcd_tick && dec_mode == m;
    endsequence

    sequence s_tick_low(logic low);
        lcd_tick && vbat_sync_q == low;
    endsequence

    chk_reserved_reads_zero: assert property (
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        AVS_READ_I && !AVS_WAITREQUEST_O && $past(hit_control) |->
            AVS_READDATA_O[CTL_RSVD] == 1'b0)
        else $error("Reserved control bit read back as one");

    chk_blank_all_off: assert property (
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        lcd_tick && blank |=> SEG_STATE_O == 128'h0 ##1 $stable(SEG_STATE_O))
        else $error("Segments on while blanked");

    chk_size_upper_off: assert property (
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        lcd_tick && !size32 |=> SEG_STATE_O[127:64] == 64'h0 && SEG_PIN_EN_O == 32'h0000_FFFF)
        else $error("Upper segment pins active in 16 pin size");

    chk_mux_field_out: assert property (
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        lcd_tick |=> MUX_MODE_O == $past(mux_sel))
        else $error("Backplane mux output differs from field");

    chk_static_bias_off: assert property (
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        lcd_tick && mux_sel == MUX_STATIC |=> !BIAS_HALF_O)
        else $error("Half bias driven in static mode");

    chk_nibble_full_map: assert property (
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        lcd_tick && disp_on && !blank && size32 && mux_sel == MUX_FOUR |=>
            SEG_STATE_O == $past(mem_bus.image))
        else $error("Segment state differs from data image");

    chk_static_low_bit: assert property (
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        lcd_tick && mux_sel == MUX_STATIC |=>
            (SEG_STATE_O & {32{4'hE}}) == 128'h0)
        else $error("Unused nibble bits reach the segments");

    chk_bypass_mode: assert property (
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        s_tick_mode(MODE_BYPASS) |=> RAIL_BYPASS_O && !PUMP_EN_O && !RAIL_REGULATE_O)
        else $error("Mode 1 not in plain bypass");

    chk_min_pump_low: assert property (
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        s_tick_mode(MODE_MIN) and s_tick_low(1'b1) |=> PUMP_EN_O && !RAIL_BYPASS_O)
        else $error("Mode 2 pump not on with battery low");

    chk_const_regulate: assert property (
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        s_tick_mode(MODE_CONST) and s_tick_low(1'b0) |=> RAIL_REGULATE_O && !PUMP_EN_O)
        else $error("Mode 3 not regulating with battery high");

    chk_auto_fallback: assert property (
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        s_tick_mode(MODE_AUTO) and s_tick_low(1'b1) |=> RAIL_BYPASS_O && !RAIL_REGULATE_O)
        else $error("Mode 4 not bypassing with battery low");

    chk_auto_no_pump: assert property (
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        mode_q == MODE_AUTO |-> !PUMP_EN_O)
        else $error("Charge pump on in mode 4");

    chk_comparator_sync: assert property (
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        $rose(VBAT_LOW_I) ##1 VBAT_LOW_I |-> ##1 vbat_sync_q)
        else $error("Battery comparator not synchronised in two stages");

endmodule // lcc_ctrl

// ### hdl/lcc_pkg.sv
// Constants, field layout and types of the LCD control and contrast block.
// Assumes one 125 MHz system clock and a register index per bus word.
package lcc_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_CONTRAST = 8'h9C;
    localparam logic [7:0] IDX_CONTROL  = 8'h9D;
    localparam logic [7:0] IDX_MASTER   = 8'hAB;
    localparam logic [7:0] IDX_MCFG     = 8'hA0;
    localparam logic [7:0] IDX_POWER    = 8'hA1;
    localparam logic [7:0] IDX_BATMON   = 8'hA2;
    localparam logic [7:0] IDX_STATUS   = 8'hA3;
    localparam int         SEG_BYTES    = 16;
    localparam logic [7:0] DATA_IDX [SEG_BYTES] = '{
        8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h91, 8'h92,
        8'h93, 8'h94, 8'h95, 8'h96, 8'h97, 8'h99, 8'h9A, 8'h9B};

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTL_RSVD    = 7;
    localparam int CTL_DIV_LO  = 5;
    localparam int CTL_BLANK   = 4;
    localparam int CTL_SIZE    = 3;
    localparam int CTL_MUX_LO  = 1;
    localparam int CTL_BIAS    = 0;
    localparam int MST_RSVD    = 7;
    localparam int MST_LOWDRV  = 2;
    localparam int MST_ENABLE  = 0;
    localparam int MCFG_BYPASS = 0;
    localparam int PWR_PUMP    = 3;
    localparam int BMON_ENABLE = 7;
    localparam int CNT_WIDTH   = 5;

    // ------------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_CONTROL  = 8'h00;
    localparam logic [7:0] RST_CONTRAST = 8'h00;
    localparam logic [7:0] RST_MASTER   = 8'h20;
    localparam logic [7:0] RST_MCFG     = 8'h00;
    localparam logic [7:0] RST_POWER    = 8'h00;
    localparam logic [7:0] RST_BATMON   = 8'h00;
    localparam logic [1:0] MUX_STATIC   = 2'h0;
    localparam logic [1:0] MUX_FOUR     = 2'h3;
    localparam logic [1:0] RD_LAST      = 2'h2;

    typedef enum logic [4:0] {
        MODE_OFF    = 5'h01,
        MODE_BYPASS = 5'h02,
        MODE_MIN    = 5'h04,
        MODE_CONST  = 5'h08,
        MODE_AUTO   = 5'h10
    } lcc_mode_t;

endpackage

// ### hdl/lcc_mem_if.sv
// Port bundle between the control block and its segment data store.
// Assumes both ends share the system clock.
`timescale 1ns/1ps
interface lcc_mem_if;
    logic         we;
    logic [3:0]   waddr;
    logic [7:0]   wdata;
    logic [3:0]   raddr;
    logic [7:0]   rdata;
    logic [127:0] image;

    modport store (input we, waddr, wdata, raddr, output rdata, image);
    modport user  (output we, waddr, wdata, raddr, input rdata, image);
endinterface

// ### hdl/lcc_seg_mem.sv
// Sixteen byte segment data store with a registered read port.
// Assumes synchronous active high reset; image shows all bytes at once.
`timescale 1ns/1ps
module lcc_seg_mem
    import lcc_pkg::*;
(
    // Clock and reset
    input  wire logic   CLK_SYS_I,
    input  wire logic   SYS_RST_I,
    // Store side
    lcc_mem_if.store    mem
);
    logic [7:0] mem_q [SEG_BYTES];
    logic [7:0] rdata_q;

    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= mem_q[mem.raddr];
        end
    end

    genvar i;
    generate
        for (i = 0; i < SEG_BYTES; i++) begin : g_byte
            always_ff @(posedge CLK_SYS_I) begin
                if (SYS_RST_I) begin
                    mem_q[i] <= 8'h00;
                end else if (mem.we && mem.waddr == 4'(i)) begin
                    mem_q[i] <= mem.wdata;
                end
            end
            assign mem.image[8*i+7:8*i] = mem_q[i];
        end
    endgenerate

    assign mem.rdata = rdata_q;
endmodule // lcc_seg_mem

// ### hdl/lcc_tick_div.sv
// Divides the low frequency oscillator into the LCD clock tick.
// Assumes the oscillator level is synchronous to the system clock.
`timescale 1ns/1ps
module lcc_tick_div
    import lcc_pkg::*;
(
    // Clock and reset
    input  wire logic       CLK_SYS_I,
    input  wire logic       SYS_RST_I,
    // Oscillator and divide code
    input  wire logic       osc_i,
    input  wire logic [1:0] div_i,
    // One cycle LCD tick
    output wire logic       tick_o
);
    logic       osc_q;
    logic [1:0] div_q;
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic [1:0] mask;
    logic       rise;
    logic       div_chg;

    // divide by 1, 2 or 4
    assign mask    = (div_i == 2'h0) ? 2'h0 : (div_i == 2'h1) ? 2'h1 : 2'h3;
    assign rise    = osc_i && !osc_q;
    assign div_chg = div_i != div_q;
    assign tick_o  = !SYS_RST_I && rise && !div_chg && ((cnt_q & mask) == mask);
    assign cnt_d   = div_chg ? 2'h0 : rise ? 2'(cnt_q + 2'h1) : cnt_q;

    // Edge history tracks the pin in reset: no false tick on release
    always_ff @(posedge CLK_SYS_I) begin
        osc_q <= osc_i;
        if (SYS_RST_I) begin
            div_q <= 2'h0;
            cnt_q <= 2'h0;
        end else begin
            div_q <= div_i;
            cnt_q <= cnt_d;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [2:0] rises_q;
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I || div_chg || tick_o) begin
            rises_q <= 3'h0;
        end else if (rise) begin
            rises_q <= 3'(rises_q + 3'h1);
        end
    end

    chk_tick_divide_ratio: assert property (
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        tick_o && $past(tick_o == 1'b0) && $stable(div_i) |->
            3'(rises_q + 3'h1) == 3'({1'b0, mask} + 3'h1))
        else $error("LCD tick spacing does not match divide code");
endmodule // lcc_tick_div

// ### testbench/lcc_glass.sv
// Passive glass model: counts the segments lit by the drive pattern.
// Assumes segment states come from the control block's registers.
`timescale 1ns/1ps
module lcc_glass (
    // Segment drive
    input  wire logic [127:0] seg_i,
    // Lit segment count
    output logic      [7:0]   lit_o
);
    assign lit_o = 8'($countones(seg_i));
endmodule // lcc_glass

// ### testbench/lcd_control_and_contrast_mode_tb_top.sv
// Self-checking bench of the LCD control and contrast block.
// Assumes design and glass model compiled first; one 125 MHz clock.
`timescale 1ns/1ps
module lcd_control_and_contrast_mode_tb_top
    import lcc_pkg::*;
();
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic [9:0]   adr = '0;
    logic         rd = 1'b0, wr = 1'b0, vlow = 1'b0, lfo;
    logic [3:0]   be = 4'hF;
    logic [31:0]  wd = '0, rdat, pen;
    logic [2:0]   lcnt = '0;
    logic [127:0] seg;
    logic [1:0]   mux;
    logic [4:0]   cset;
    logic [7:0]   lit;
    logic         wreq, bhalf, tick, byp, rreg, pump;
    int           num_errors = 0;
    int           num_checks = 0;

    always #4 clk = ~clk;
    // Oscillator at one eighth of the system clock
    always @(posedge clk) lcnt <= lcnt + 3'h1;
    assign lfo = lcnt[2];

    lcc_ctrl i_dut (.CLK_SYS_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(be), .AVS_WRITEDATA_I(wd), .AVS_READDATA_O(rdat),
        .AVS_WAITREQUEST_O(wreq), .LFO_CLK_I(lfo), .VBAT_LOW_I(vlow), .SEG_STATE_O(seg),
        .SEG_PIN_EN_O(pen), .MUX_MODE_O(mux), .BIAS_HALF_O(bhalf), .LCD_TICK_O(tick),
        .CONTRAST_SET_O(cset), .RAIL_BYPASS_O(byp), .RAIL_REGULATE_O(rreg), .PUMP_EN_O(pump));
    lcc_glass i_glass (.seg_i(seg), .lit_o(lit));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic bus(input logic r, input logic [7:0] idx, input logic [7:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        adr <= {idx, 2'h0};
        rd <= r;
        wr <= ~r;
        be <= 4'hF;
        wd <= {24'h0, d};
        @(posedge clk);
        while (wreq !== 1'b0) @(posedge clk);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            @(negedge clk);
            while (tick !== 1'b1) @(negedge clk);
        end
        @(negedge clk);
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        logic [31:0] q;
        bus(1'b1, IDX_CONTROL, 8'h00, q);
        chk("control reset", q, {24'h0, RST_CONTROL});
        bus(1'b0, IDX_CONTROL, 8'hFF, q);
        bus(1'b1, IDX_CONTROL, 8'h00, q);
        chk("control top bit", q, 32'h7F);
        bus(1'b1, 8'h00, 8'h00, q);
        chk("unmapped read", q, 32'h0);
        bus(1'b0, IDX_CONTRAST, 8'hFF, q);
        ticks(2);
        chk("contrast code", 32'(cset), 32'h1F);
        $display("test regs done");
    endtask

    task automatic t_div();
        logic [31:0] q;
        int n;
        for (int d = 0; d < 4; d++) begin
            bus(1'b0, IDX_CONTROL, 8'(d << CTL_DIV_LO), q);
            ticks(2);
            n = 0;
            repeat (64) begin
                @(negedge clk);
                n += int'(tick === 1'b1);
            end
            chk("ticks in 8 periods", n, 8 >> (d == 3 ? 2 : d));
        end
        $display("test divide done");
    endtask

    task automatic t_seg();
        logic [31:0] q;
        logic [3:0]  mk;
        foreach (DATA_IDX[k]) bus(1'b0, DATA_IDX[k], 8'hFF, q);
        for (int m = 0; m < 4; m++) begin
            for (int s = 0; s < 2; s++) begin
                mk = 4'hF >> (3 - m);
                bus(1'b0, IDX_MASTER, 8'h00, q);
                bus(1'b0, IDX_CONTROL, 8'((s << CTL_SIZE) | (m << CTL_MUX_LO) | 1), q);
                bus(1'b0, IDX_MASTER, 8'h01, q);
                ticks(2);
                chk("mux", 32'(mux), 32'(m));
                chk("bias", 32'(bhalf), 32'(m != 0));
                chk("pin 0", 32'(seg[3:0]), 32'(mk));
                chk("pin 31", 32'(seg[127:124]), s ? 32'(mk) : 32'h0);
                chk("pins used", pen, s ? 32'hFFFF_FFFF : 32'h0000_FFFF);
                chk("lit", 32'(lit), (16 << s) * (m + 1));
            end
        end
        // Blank with four-mux and all pins
        bus(1'b0, IDX_CONTROL, 8'h1E, q);
        ticks(2);
        chk("blank", 32'(seg == 128'h0), 32'h1);
        $display("test segments done");
    endtask

    task automatic t_mode();
        logic [31:0] q;
        logic [3:0]  p;
        logic [3:0]  pat [5] = '{4'h4, 4'h7, 4'hB, 4'h9, 4'h3};
        logic [5:0]  ex  [5] = '{6'h24, 6'h21, 6'h11, 6'h14, 6'h11};
        for (int i = 0; i < 5; i++) begin
            p = pat[i];
            for (int b = 0; b < 2; b++) begin
                @(posedge clk);
                vlow <= b[0];
                bus(1'b0, IDX_MASTER, {5'h0, p[3], 2'h1}, q);
                bus(1'b0, IDX_MCFG, {7'h0, p[2]}, q);
                bus(1'b0, IDX_POWER, {4'h0, p[1], 3'h0}, q);
                bus(1'b0, IDX_BATMON, {p[0], 7'h0}, q);
                ticks(3);
                chk("rails", 32'({byp, rreg, pump}), 32'(b ? ex[i][2:0] : ex[i][5:3]));
            end
        end
        $display("test modes done");
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_div();
        t_seg();
        t_mode();
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        stop_test();
    end
endmodule // lcd_control_and_contrast_mode_tb_top
